//--- rtl/adcso_defs.svh
// constants of the result serialiser: word layout, timing figures, derived counts
// assumes the including file runs on clk_sys at 200 MHz
`ifndef ADCSO_DEFS_SVH
`define ADCSO_DEFS_SVH

`define ADCSO_WORD_BITS 24
`define ADCSO_CODE_BITS 22
`define ADCSO_RAW_BITS 24
`define ADCSO_EOC_POS 23
`define ADCSO_FILLER_POS 22
`define ADCSO_SIGN_POS 21
`define ADCSO_LAST_FALL 5'h17
`define ADCSO_CODE_POS_FS 24'sh100000
`define ADCSO_CODE_NEG_FS_M1 24'shefffff
`define ADCSO_CODE_FLIP 22'h200000

`define ADCSO_CLK_PERIOD_NS 5
`define ADCSO_CONV_TICKS 10278
`define ADCSO_NOTCH_DIV 2560
`define ADCSO_SCK_HALF_TICKS 4
`define ADCSO_CONV_60HZ_NS 67000000
`define ADCSO_CONV_50HZ_NS 80000000
`define ADCSO_EXT_MIN_PERIOD_NS 200000
`define ADCSO_TICK60_CYC (`ADCSO_CONV_60HZ_NS / (`ADCSO_CLK_PERIOD_NS * `ADCSO_CONV_TICKS))
`define ADCSO_TICK50_CYC (`ADCSO_CONV_50HZ_NS / (`ADCSO_CLK_PERIOD_NS * `ADCSO_CONV_TICKS))
`define ADCSO_EXT_DET_CYC (`ADCSO_EXT_MIN_PERIOD_NS / `ADCSO_CLK_PERIOD_NS)
`define ADCSO_INIT_CYC 2'h3

`endif

//--- rtl/adcso_pkg.sv
// types shared by the result serialiser files
// assumes adcso_defs.svh is on the include path
`include "adcso_defs.svh"
package adcso_pkg;
	typedef enum logic [2:0] {
		ADCSO_CONV = 3'b001,
		ADCSO_SLEEP = 3'b010,
		ADCSO_OUT = 3'b100
	} adcso_state_e;

	// filter result, two's complement, full scale at +/- 2**20 lsb
	typedef struct packed {
		logic signed [`ADCSO_RAW_BITS-1:0] raw;
	} adcso_result_s;

	typedef struct packed {
		logic cs_n;
		logic sck;
		logic rate;
	} adcso_pins_s;
endpackage

//--- rtl/adcso_sync.sv
// two flip-flop synchroniser for a group of pin levels
// assumes asynchronous inputs and a single clk_sys domain
`timescale 1ns/10ps
module adcso_sync #(
	parameter int W = 3,
	// reset level per bit: the idle level of each pin, so no false edge follows reset
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	generate
		if (W < 1) begin : g_chk
			$error("adcso_sync width must be at least one");
		end
	endgenerate

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
		end else begin
			meta_q <= d;
			sync_q <= meta_q;
		end
	end

	assign q = sync_q;
endmodule

//--- rtl/adcso_fifo.sv
// result fifo between the digital filter and the serialiser
// assumes both sides on clk_sys; depth a power of two
`timescale 1ns/10ps
module adcso_fifo #(
	parameter int W = 24,
	parameter int DEPTH = 8
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW:0] wr_q;
	logic [AW:0] rd_q;
	wire push = in_valid & in_ready;
	wire pop = out_valid & out_ready;

	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
			$error("adcso_fifo depth must be a power of two, at least two");
		end
	endgenerate

	assign in_ready = (wr_q ^ rd_q) != {1'b1, {AW{1'b0}}};
	assign out_valid = wr_q != rd_q;
	assign out_data = mem[rd_q[AW-1:0]];

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wr_q[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			wr_q <= wr_q + (AW+1)'(push);
			rd_q <= rd_q + (AW+1)'(pop);
		end
	end
endmodule

//--- rtl/adcso_top.sv
// delta-sigma result serialiser: conversion timing, clock source choice,
// result word formatting and the three-wire serial port
// assumes the filter pushes one result per conversion through res_*,
// pins are asynchronous and the pad logic resolves the *_oe enables
//
// Behaviour
// - each result leaves as a serial word of exactly 24 bits.
// - first three bits are status, then 21 result bits msb first.
// - bit 23 is high during conversion, low once it completes.
// - while converting or sleeping, data out shows the done flag when select low.
// - bit 22 is always a zero filler.
// - bit 21 is the sign, set for positive or zero input.
// - overrange sets bits 21 and 20, underrange clears both.
// - bits 20 to 0 carry the result, msb first, bit 0 lsb.
// - select high: data out floats and serial clock pulses are ignored.
// - host takes bit 23 on first rise; bit 22 leaves on first fall.
// - bit 0 leaves on 23rd fall; host latches it on 24th rise.
// - 24th fall switches data out to the next done flag.
// - done flag drops in real time when a conversion finishes.
// - clamp above full scale to +fs code, below to -fs minus one lsb.
// - internal oscillator: rate pin low gives 60 hz, high gives 50 hz.
// - rate change only disturbs the conversion in progress.
// - external clock on rate pin detected automatically, oscillator then off.
// - external clock: notch at clock over 2560, conversion counted in its rising edges.
// - without external clock, internal oscillator runs, internal mode entered.
// - clock source change only disturbs the conversion in progress.
// - source change in internal sck mode keeps serial data valid.
// - output ends after 24 bits or select high, then converts again, or sleeps if select rose before any sck rise.
// - internal sck mode drives serial clock at conversion clock over 8.
// - sck level at reset and each select fall picks the sck mode.
`timescale 1ns/10ps
module adcso_top
	import adcso_pkg::*;
#(
	parameter int FIFO_DEPTH = 8,
	parameter int CONV_TICKS = `ADCSO_CONV_TICKS,
	parameter int EXT_DET_CYC = `ADCSO_EXT_DET_CYC
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic cs_n_pin,
	input wire logic sck_pin_i,
	output logic sck_pin_o,
	output logic sck_pin_oe,
	output logic sdo_pin_o,
	output logic sdo_pin_oe,
	input wire logic rate_select_pin,
	input wire logic res_valid,
	output logic res_ready,
	input wire adcso_result_s res_data,
	output logic conv_tick,
	output logic conv_start,
	output logic conv_busy,
	output logic osc_en,
	output logic ext_clk_mode,
	output logic notch_50hz,
	output logic sck_int_mode
);
	localparam int DW = $bits(adcso_result_s);
	localparam int CW = $clog2(CONV_TICKS + 1);
	localparam int EW = $clog2(EXT_DET_CYC + 1);
	localparam int TW = $clog2(`ADCSO_TICK50_CYC + 1);
	localparam logic [CW-1:0] CONV_LAST = CW'(CONV_TICKS - 1);
	localparam logic [EW-1:0] EXT_LIM = EW'(EXT_DET_CYC);
	localparam logic [TW-1:0] TICK60_LAST = TW'(`ADCSO_TICK60_CYC - 1);
	localparam logic [TW-1:0] TICK50_LAST = TW'(`ADCSO_TICK50_CYC - 1);
	localparam logic [1:0] SCK_HALF_LAST = 2'(`ADCSO_SCK_HALF_TICKS - 1);
	// idle pin levels: select released, sck low, rate low
	localparam adcso_pins_s PINS_IDLE = '{cs_n: 1'b1, sck: 1'b0, rate: 1'b0};

	generate
		if (CONV_TICKS < 2) begin : g_chk_conv
			$error("adcso_top conversion length too short");
		end
		if (EXT_DET_CYC < 4) begin : g_chk_det
			$error("adcso_top detection window too short");
		end
		if (FIFO_DEPTH < 2) begin : g_chk_fifo
			$error("adcso_top result fifo too shallow");
		end
		// the oscillator divider must serve both line rates
		if (`ADCSO_TICK60_CYC < 2 || `ADCSO_TICK50_CYC < `ADCSO_TICK60_CYC) begin : g_chk_osc
			$error("adcso_top oscillator divider out of range");
		end
	endgenerate

	// pin synchronisation
	adcso_pins_s pins_raw;
	adcso_pins_s pins_s;
	adcso_pins_s pins_prev_q;

	assign pins_raw = '{cs_n: cs_n_pin, sck: sck_pin_i, rate: rate_select_pin};

	// select must leave reset high, or a false select fall drives sdo
	adcso_sync #(
		.W($bits(adcso_pins_s)),
		.RST_VAL(PINS_IDLE)
	) u_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.d(pins_raw),
		.q(pins_s)
	);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pins_prev_q <= PINS_IDLE;
		end else begin
			pins_prev_q <= pins_s;
		end
	end

	wire cs_low = ~pins_s.cs_n;
	wire cs_fall = pins_prev_q.cs_n & ~pins_s.cs_n;
	wire ext_sck_rise = pins_s.sck & ~pins_prev_q.sck;
	wire ext_sck_fall = ~pins_s.sck & pins_prev_q.sck;
	wire rate_rise = pins_s.rate & ~pins_prev_q.rate;

	// result fifo from the filter
	logic fifo_out_valid;
	logic fifo_pop;
	adcso_result_s fifo_out;

	adcso_fifo #(
		.W(DW),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.in_valid(res_valid),
		.in_ready(res_ready),
		.in_data(res_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out)
	);

	// external conversion clock detection
	logic [EW-1:0] gap_q;
	logic ext_q;
	wire gap_full = gap_q >= EXT_LIM;
	wire [EW-1:0] gap_d = rate_rise ? '0 : (gap_full ? gap_q : gap_q + EW'(1));
	// two edges closer than the slowest legal external period mean a clock
	wire ext_d = rate_rise ? ~gap_full : (gap_full ? 1'b0 : ext_q);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			gap_q <= EXT_LIM;
			ext_q <= 1'b0;
		end else begin
			gap_q <= gap_d;
			ext_q <= ext_d;
		end
	end

	// internal oscillator model, divided down from clk_sys
	logic [TW-1:0] osc_cnt_q;
	wire [TW-1:0] osc_last = pins_s.rate ? TICK50_LAST : TICK60_LAST;
	// compare with >= so a mid-period rate change never runs the counter past its wrap
	wire osc_wrap = osc_cnt_q >= osc_last;
	wire osc_tick = ~ext_q & osc_wrap;
	wire [TW-1:0] osc_cnt_d = (ext_q || osc_wrap) ? '0 : osc_cnt_q + TW'(1);
	// with an external clock every rising edge is one conversion clock period
	wire tick = ext_q ? rate_rise : osc_tick;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			osc_cnt_q <= '0;
		end else begin
			osc_cnt_q <= osc_cnt_d;
		end
	end

	// result formatting: clamp, then offset binary by flipping the sign
	wire signed [`ADCSO_RAW_BITS-1:0] raw = fifo_out.raw;
	wire over = raw > `ADCSO_CODE_POS_FS;
	wire under = raw < `ADCSO_CODE_NEG_FS_M1;
	wire signed [`ADCSO_RAW_BITS-1:0] clamped = over ? `ADCSO_CODE_POS_FS :
		(under ? `ADCSO_CODE_NEG_FS_M1 : raw);
	wire [`ADCSO_CODE_BITS-1:0] code = clamped[`ADCSO_CODE_BITS-1:0] ^ `ADCSO_CODE_FLIP;
	// done flag low and filler zero lead the 22 code bits
	wire [`ADCSO_WORD_BITS-1:0] word_new = {1'b0, 1'b0, code};

	// control state
	adcso_state_e state_q;
	adcso_state_e state_d;
	logic [CW-1:0] conv_cnt_q;
	logic [`ADCSO_WORD_BITS-1:0] word_q;
	logic [4:0] fall_cnt_q;
	logic seen_rise_q;
	logic sck_int_mode_q;
	logic [1:0] init_q;
	logic sck_int_q;
	logic [1:0] half_q;
	logic sdo_q;
	logic sdo_oe_q;
	logic sck_oe_q;
	logic tick_q;
	logic start_q;

	wire in_conv = state_q == ADCSO_CONV;
	wire in_sleep = state_q == ADCSO_SLEEP;
	wire in_out = state_q == ADCSO_OUT;
	wire conv_count = in_conv & tick & (conv_cnt_q <= CONV_LAST);
	// the conversion only completes once its filtered result is at hand
	wire conv_end = in_conv & (conv_cnt_q > CONV_LAST) & fifo_out_valid;
	assign fifo_pop = conv_end;

	// internal serial clock, toggled every four conversion ticks
	wire int_drive = in_out & sck_int_mode_q & cs_low;
	wire int_toggle = int_drive & tick & (half_q == SCK_HALF_LAST);
	wire int_rise = int_toggle & ~sck_int_q;
	wire int_fall = int_toggle & sck_int_q;

	// edges are seen only while selected in the output state
	wire sck_rise = in_out & cs_low & (sck_int_mode_q ? int_rise : ext_sck_rise);
	wire sck_fall = in_out & cs_low & seen_rise_q &
		(sck_int_mode_q ? int_fall : ext_sck_fall);
	wire last_fall = sck_fall & (fall_cnt_q == `ADCSO_LAST_FALL);
	// select high ends output; a read already begun restarts conversion
	wire out_abort = in_out & ~cs_low;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ADCSO_CONV: begin
				if (conv_end) begin
					state_d = ADCSO_SLEEP;
				end
			end
			ADCSO_SLEEP: begin
				if (cs_low) begin
					state_d = ADCSO_OUT;
				end
			end
			ADCSO_OUT: begin
				if (out_abort) begin
					state_d = seen_rise_q ? ADCSO_CONV : ADCSO_SLEEP;
				end else if (last_fall) begin
					state_d = ADCSO_CONV;
				end
			end
		endcase
	end

	wire enter_conv = in_out & (state_d == ADCSO_CONV);
	wire [CW-1:0] conv_cnt_d = enter_conv ? '0 :
		(conv_count ? conv_cnt_q + CW'(1) : conv_cnt_q);

	// shift on each counted fall; the register holds the result through sleep
	wire [`ADCSO_WORD_BITS-1:0] word_d = conv_end ? word_new :
		(sck_fall ? {word_q[`ADCSO_WORD_BITS-2:0], 1'b0} : word_q);
	wire [4:0] fall_cnt_d = in_out ? fall_cnt_q + 5'(sck_fall) : 5'h00;
	wire seen_rise_d = in_out & ~out_abort & (seen_rise_q | sck_rise);

	// sck mode sampled once after reset release and at every select fall
	wire mode_load = cs_fall | (init_q == `ADCSO_INIT_CYC - 2'h1);
	wire sck_int_mode_d = mode_load ? pins_s.sck : sck_int_mode_q;

	wire sck_int_d = int_drive ? (sck_int_q ^ int_toggle) : 1'b1;
	wire [1:0] half_d = int_drive ? (tick ? half_q + 2'h1 : half_q) : 2'h0;

	// done flag follows the state in real time outside the output state
	wire sdo_d = in_out & ~last_fall & ~out_abort ?
		(sck_fall ? word_q[`ADCSO_WORD_BITS-2] : word_q[`ADCSO_EOC_POS]) :
		((in_conv & ~conv_end) | enter_conv);

	// conversion starts straight out of reset
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ADCSO_CONV;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			conv_cnt_q <= '0;
		end else begin
			conv_cnt_q <= conv_cnt_d;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			word_q <= '0;
		end else begin
			word_q <= word_d;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			fall_cnt_q <= 5'h00;
		end else begin
			fall_cnt_q <= fall_cnt_d;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			seen_rise_q <= 1'b0;
		end else begin
			seen_rise_q <= seen_rise_d;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			init_q <= 2'h0;
			sck_int_mode_q <= 1'b1;
			sck_int_q <= 1'b1;
			half_q <= 2'h0;
		end else begin
			init_q <= (init_q == `ADCSO_INIT_CYC) ? init_q : init_q + 2'h1;
			sck_int_mode_q <= sck_int_mode_d;
			sck_int_q <= sck_int_d;
			half_q <= half_d;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sdo_q <= 1'b1;
			sdo_oe_q <= 1'b0;
			sck_oe_q <= 1'b0;
			tick_q <= 1'b0;
			start_q <= 1'b0;
		end else begin
			sdo_q <= sdo_d;
			sdo_oe_q <= cs_low;
			sck_oe_q <= int_drive;
			tick_q <= tick;
			start_q <= enter_conv;
		end
	end

	assign sdo_pin_o = sdo_q;
	assign sdo_pin_oe = sdo_oe_q;
	assign sck_pin_o = sck_int_q;
	assign sck_pin_oe = sck_oe_q;
	assign conv_tick = tick_q;
	assign conv_start = start_q;
	assign conv_busy = in_conv;
	assign osc_en = ~ext_q;
	assign ext_clk_mode = ext_q;
	assign notch_50hz = pins_s.rate & ~ext_q;
	assign sck_int_mode = sck_int_mode_q;
endmodule

//--- tb/adcso_monitor.sv
// checker for the result serialiser top: pin, state and clock-source relations
// assumes bound to adcso_top, single clk_sys domain, rst_n async active low
`timescale 1ns/10ps
module adcso_monitor (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic cs_n_pin,
	input wire logic sdo_pin_o,
	input wire logic sdo_pin_oe,
	input wire logic sck_pin_oe,
	input wire logic conv_tick,
	input wire logic conv_start,
	input wire logic conv_busy,
	input wire logic osc_en,
	input wire logic ext_clk_mode,
	input wire logic notch_50hz,
	input wire logic sck_int_mode
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	AST_SDO_FLOAT: assert property (cs_n_pin [*5] |-> !sdo_pin_oe)
		else $error("sdo driven with select high");
	AST_SDO_DRIVE: assert property ((!cs_n_pin) [*5] |-> sdo_pin_oe)
		else $error("sdo not driven with select low");
	AST_BUSY_FLAG: assert property (conv_busy && $past(conv_busy) && sdo_pin_oe |-> sdo_pin_o)
		else $error("done flag low during conversion");
	AST_DONE_DROP: assert property ($fell(conv_busy) |-> !sdo_pin_o)
		else $error("done flag late at conversion end");
	AST_START_BUSY: assert property (conv_start |-> ##[0:1] conv_busy)
		else $error("start without conversion");
	AST_SCK_DRIVE: assert property (sck_pin_oe |-> sck_int_mode)
		else $error("sck driven in external sck mode");
	AST_EXT_OFF: assert property ($rose(ext_clk_mode) |-> ##[0:1] !osc_en)
		else $error("oscillator left on with external clock");
	AST_INT_ON: assert property ($fell(ext_clk_mode) |-> ##[0:1] osc_en)
		else $error("oscillator off without external clock");
	AST_NOTCH: assert property (notch_50hz |-> osc_en)
		else $error("50 hz notch outside internal mode");
	AST_TICK: assert property (conv_tick |=> !conv_tick)
		else $error("conversion tick wider than one cycle");
endmodule

bind adcso_top adcso_monitor i_mon (.clk_sys, .rst_n, .cs_n_pin, .sdo_pin_o, .sdo_pin_oe,
	.sck_pin_oe, .conv_tick, .conv_start, .conv_busy, .osc_en, .ext_clk_mode, .notch_50hz,
	.sck_int_mode);

//--- tb/adcso_host.sv
// host model: reads result words over the three-wire port with its own sck or the device sck
// assumes pins change at falling clk_sys; sck low at select fall picks external sck mode,
// sck high picks internal mode, where the device sck comes back on sck_in
`timescale 1ns/10ps
module adcso_host (
	input wire logic clk_sys,
	input wire logic sdo,
	input wire logic sck_in,
	output logic cs_n,
	output logic sck
);
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
	end

	// nb below 24 aborts the read early
	task automatic read_word(input int nb, input int wait_max, output logic [23:0] w,
		output logic got, output logic nx);
		int n;
		w = '0;
		n = 0;
		@(negedge clk_sys);
		cs_n <= 1'b0; // sck low at select fall
		repeat (6) @(negedge clk_sys);
		while (sdo !== 1'b0 && n < wait_max) begin
			@(negedge clk_sys);
			n++;
		end
		got = (sdo === 1'b0);
		for (int i = 0; got && i < nb; i++) begin
			w[23-i] = sdo; // taken as sck rises
			sck <= 1'b1;
			repeat (4) @(negedge clk_sys);
			sck <= 1'b0;
			repeat (6) @(negedge clk_sys);
		end
		nx = sdo;
		cs_n <= 1'b1;
		repeat (8) @(negedge clk_sys);
	endtask

	// device drives sck; each bit is taken after a device sck rise
	task automatic read_int(input int wait_max, output logic [23:0] w, output logic got,
		output logic nx, output int per);
		int n;
		realtime t0;
		w = '0;
		n = 0;
		per = 0;
		t0 = 0.0;
		@(negedge clk_sys);
		sck <= 1'b1;
		repeat (4) @(negedge clk_sys);
		cs_n <= 1'b0; // sck high at select fall
		repeat (6) @(negedge clk_sys);
		while (sdo !== 1'b0 && n < wait_max) begin
			@(negedge clk_sys);
			n++;
		end
		got = (sdo === 1'b0);
		for (int i = 0; got && i < 24; i++) begin
			@(posedge sck_in);
			@(negedge clk_sys);
			w[23-i] = sdo; // taken after sck rises
			if (i == 0)
				t0 = $realtime;
			if (i == 1)
				per = int'(($realtime - t0) / 5.0);
		end
		if (got)
			@(negedge sck_in);
		repeat (6) @(negedge clk_sys);
		nx = sdo;
		cs_n <= 1'b1;
		repeat (4) @(negedge clk_sys);
		sck <= 1'b0;
		repeat (8) @(negedge clk_sys);
	endtask
endmodule

//--- tb/tb_top.sv
// self-checking bench for the result serialiser top with a host model
// assumes shortened conversion and detection counts; rate pin runs an 8-cycle clock
`timescale 1ns/10ps
module tb_top
	import adcso_pkg::*;
;
	logic clk_sys, rst_n, h_cs, h_sck, sck_w, sdo_w, sdo_prev, rate_run, rate_lvl, rate_w;
	logic sck_pin_o, sck_pin_oe, sdo_pin_o, sdo_pin_oe, res_valid, res_ready;
	logic conv_tick, conv_start, conv_busy, osc_en, ext_clk_mode, notch_50hz, sck_int_mode;
	logic [2:0] rcnt = 3'h0;
	adcso_result_s res_data;
	int bad_count = 0;
	int checks = 0;
	int cyc = 0;
	int vals[8] = '{0, -1, 1048576, 1048581, 524288, -1048576, -1048590, 1048575};

	always #2.5 clk_sys = ~clk_sys;
	always @(negedge clk_sys) rcnt <= rcnt + 3'h1;
	assign rate_w = rate_run ? rcnt[2] : rate_lvl;
	assign sck_w = sck_pin_oe ? sck_pin_o : h_sck;
	// a released line shows the inverse, so a stale level never passes
	always @(posedge clk_sys) if (sdo_pin_oe) sdo_prev <= sdo_pin_o;
	assign sdo_w = sdo_pin_oe ? sdo_pin_o : ~sdo_prev;

	adcso_top #(.CONV_TICKS(40), .EXT_DET_CYC(64)) i_dut (.clk_sys, .rst_n, .cs_n_pin(h_cs),
		.sck_pin_i(sck_w), .sck_pin_o, .sck_pin_oe, .sdo_pin_o, .sdo_pin_oe,
		.rate_select_pin(rate_w), .res_valid, .res_ready, .res_data, .conv_tick, .conv_start,
		.conv_busy, .osc_en, .ext_clk_mode, .notch_50hz, .sck_int_mode);
	adcso_host i_host (.clk_sys, .sdo(sdo_w), .sck_in(sck_w), .cs_n(h_cs), .sck(h_sck));

	task automatic close_out();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			bad_count++;
			close_out();
		end
	end

	task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	function automatic logic [23:0] exp_word(input int r);
		int c;
		c = r > 1048576 ? 1048576 : (r < -1048577 ? -1048577 : r);
		return {2'b00, 22'(c) ^ 22'h200000};
	endfunction

	task automatic t_stream();
		logic [23:0] w;
		logic got, nx;
		for (int i = 0; i < 8; i++) begin
			@(negedge clk_sys);
			res_valid = 1'b1;
			res_data.raw = 24'(vals[i]);
		end
		@(negedge clk_sys);
		chk(24'(res_ready), 24'h0, "full fifo refuses");
		res_valid = 1'b0;
		for (int i = 0; i < 8; i++) begin
			i_host.read_word(24, 2000, w, got, nx);
			chk(24'(got), 24'h1, "done flag");
			chk(w, exp_word(vals[i]), "word");
			chk(24'(nx), 24'h1, "next done flag");
		end
		chk(24'(sck_int_mode), 24'h0, "sck mode");
		// fifo now empty: conversion stalls with the flag high
		i_host.read_word(24, 600, w, got, nx);
		chk(24'(got), 24'h0, "stalled flag");
		$display("test stream done");
	endtask

	task automatic t_abort();
		logic [23:0] w;
		logic got, nx;
		@(negedge clk_sys);
		res_valid = 1'b1;
		res_data.raw = 24'h000123;
		@(negedge clk_sys);
		res_valid = 1'b0;
		i_host.read_word(3, 2000, w, got, nx);
		chk(w, 24'h200000, "status bits");
		chk(24'(conv_busy), 24'h1, "abort restarts");
		chk(24'(sdo_pin_oe), 24'h0, "sdo floats");
		$display("test abort done");
	endtask

	task automatic t_int_sck();
		logic [23:0] w;
		logic got, nx;
		int per;
		@(negedge clk_sys);
		res_valid = 1'b1;
		res_data.raw = 24'hf80000;
		@(negedge clk_sys);
		res_valid = 1'b0;
		i_host.read_int(2000, w, got, nx, per);
		chk(24'(got), 24'h1, "internal sck done flag");
		chk(w, exp_word(-524288), "internal sck word");
		chk(24'(nx), 24'h1, "internal sck next flag");
		chk(24'(per), 24'h40, "sck period of eight conversion clocks");
		chk(24'({sck_int_mode, sck_pin_oe}), 24'h2, "internal mode, sck released");
		$display("test internal sck done");
	endtask

	task automatic t_rate();
		rate_run = 1'b0;
		rate_lvl = 1'b1;
		repeat (100) @(negedge clk_sys);
		chk(24'({ext_clk_mode, osc_en, notch_50hz}), 24'h3, "internal 50 hz");
		rate_lvl = 1'b0;
		repeat (4) @(negedge clk_sys);
		chk(24'({ext_clk_mode, osc_en, notch_50hz}), 24'h2, "internal 60 hz");
		rate_run = 1'b1;
		repeat (40) @(negedge clk_sys);
		chk(24'({ext_clk_mode, osc_en, notch_50hz}), 24'h4, "external clock");
		$display("test rate done");
	endtask

	initial begin
		clk_sys = 1'b0;
		rst_n = 1'b0;
		res_valid = 1'b0;
		res_data = '0;
		rate_run = 1'b1;
		rate_lvl = 1'b0;
		sdo_prev = 1'b0;
		repeat (16) @(negedge clk_sys);
		rst_n = 1'b1;
		t_stream();
		t_abort();
		t_int_sck();
		t_rate();
		close_out();
	end
endmodule
